// *** hw/cfoa_pkg.sv ***
// Shared constants and types for the flag register and operand addressing block
package cfoa_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_PTR1    = 8'h04;
    localparam logic [7:0] OFS_PTR2    = 8'h08;
    localparam logic [7:0] OFS_PC      = 8'h0C;
    localparam logic [7:0] OFS_CTRL    = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_EA      = 8'h18;
    localparam logic [7:0] OFS_OPERAND = 8'h1C;

    // Flag bit positions, bit 7 down to bit 0
    localparam int F_HALT  = 7;
    localparam int F_PRIO  = 6;
    localparam int F_HALF  = 5;
    localparam int F_GMASK = 4;
    localparam int F_MSB   = 3;
    localparam int F_NULL  = 2;
    localparam int F_RANGE = 1;
    localparam int F_BORROW = 0;

    // Update enables carried with an ALU result
    localparam int U_BORROW = 0;
    localparam int U_RANGE  = 1;
    localparam int U_HALF   = 2;
    localparam int U_NZ     = 3;

    // Reset values
    localparam logic [7:0]  FLAGS_RST = 8'hD0;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    // Page prefix bytes and the stop opcode
    localparam logic [7:0] PFX_PAGE2 = 8'h18;
    localparam logic [7:0] PFX_PAGE3 = 8'h1A;
    localparam logic [7:0] PFX_PAGE4 = 8'hCD;
    localparam logic [7:0] OPC_STOP  = 8'hCF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC  = 3'b001,
        ST_OPND = 3'b010,
        ST_DATA = 3'b011,
        ST_DONE = 3'b100
    } cfoa_state_t;

    typedef enum logic [2:0] {
        M_INH = 3'b000,
        M_IMM = 3'b001,
        M_DIR = 3'b010,
        M_EXT = 3'b011,
        M_IDX = 3'b100,
        M_REL = 3'b101
    } cfoa_mode_t;
endpackage

// *** hw/cfoa_flag_calc.sv ***
// Result flag computation for one ALU outcome
module cfoa_flag_calc (
    // Current flags and ALU outcome
    input  wire logic [7:0]  flags_in,
    input  wire logic [15:0] result,
    input  wire logic        wide,
    input  wire logic        carry,
    input  wire logic        overflow,
    input  wire logic        half,
    input  wire logic [3:0]  upd,
    // Updated flags
    output logic      [7:0]  flags_out
);
    logic msb;
    logic zero;

    always_comb begin
        msb  = wide ? result[15] : result[7];
        zero = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
        flags_out = flags_in;
        if (upd[cfoa_pkg::U_BORROW]) begin
            flags_out[cfoa_pkg::F_BORROW] = carry;
        end
        if (upd[cfoa_pkg::U_RANGE]) begin
            flags_out[cfoa_pkg::F_RANGE] = overflow;
        end
        if (upd[cfoa_pkg::U_HALF]) begin
            flags_out[cfoa_pkg::F_HALF] = half;
        end
        if (upd[cfoa_pkg::U_NZ]) begin
            flags_out[cfoa_pkg::F_NULL] = zero;
            flags_out[cfoa_pkg::F_MSB]  = msb;
        end
    end
endmodule

// *** hw/cfoa_core.sv ***
// Flag register, operand fetch and effective address formation with AHB-Lite registers
// How it works
// - An 8-bit flag register holds last results; software reads each bit.
// - Borrow-out flag follows ALU carry or borrow, also on shifts and rotates.
// - Signed range error flag set on overflow, cleared otherwise.
// - Result null flag set when the result is zero, else cleared.
// - Msb set flag copies the result's top bit.
// - General mask flag blocks maskable interrupts; hardware or program sets it.
// - Low nibble carry flag reflects carry from bit 3 into 4 on adds.
// - Priority mask set only by reset or nonmaskable acknowledge; program only clears.
// - Halt block flag set makes stop a no-operation; clear lets stop act.
// - Immediate operand bytes follow the opcode, one or two by register width.
// - Direct address is zero high byte plus one operand byte.
// - Direct mode fetches no high address byte, saving one access.
// - Extended mode takes two following bytes as the absolute address.
// - Indexed address is pointer plus unsigned 8-bit offset over 64 Kbytes.
// - Inherent mode needs only the opcode; no memory operand access.
// - Taken branch adds signed byte to the program counter; else falls through.
// - No prefix is page 1; prefixes 18, 1A, CD select pages 2, 3, 4.
// - First pointer is 16 bits and is the indexed base on pages 1 and 3.
module cfoa_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Opcode and operand memory
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    // ALU outcome
    input  wire logic        alu_valid,
    input  wire logic [15:0] alu_result,
    input  wire logic        alu_wide,
    input  wire logic        alu_carry,
    input  wire logic        alu_overflow,
    input  wire logic        alu_half,
    input  wire logic [3:0]  alu_upd,
    // Sequencer events
    input  wire logic        nmi_ack,
    input  wire logic        imask_set,
    input  wire logic        ret_valid,
    input  wire logic [7:0]  ret_flags,
    // Interrupt request pin and gated result
    input  wire logic        irq_pin,
    output logic             irq_pending,
    // Decode results
    output logic             dec_done,
    output logic             stop_enter
);
    cfoa_pkg::cfoa_state_t state_reg, state_next;
    cfoa_pkg::cfoa_mode_t  mode_reg, mode_next, opc_mode;
    logic [7:0]  flags_reg, flags_next, alu_flags;
    logic [15:0] ptr1_reg, ptr1_next, ptr2_reg, ptr2_next;
    logic [15:0] pc_reg, pc_next, ea_reg, ea_next, opnd_reg, opnd_next;
    logic [7:0]  opc_reg, opc_next;
    logic [1:0]  page_reg, page_next, cnt_reg, cnt_next, opc_len;
    logic        pfx_reg, pfx_next, taken_reg, taken_next, stopign_reg, stopign_next;
    logic        stop_reg, stop_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        irq_meta_reg, irq_sync_reg, irq_pend_reg;
    logic        addr_ok, wr_flags, wr_ctrl, is_pfx, cond, fin;
    logic [15:0] rel_tgt, base_ptr;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign irq_pending = irq_pend_reg;
    assign dec_done  = (state_reg == cfoa_pkg::ST_DONE);
    assign stop_enter = stop_reg;
    assign mem_addr  = (state_reg == cfoa_pkg::ST_DATA) ? ea_reg : pc_reg;

    // Bus write lands in its data phase
    assign addr_ok  = hsel && htrans[1] && hready;
    assign wr_flags = wr_pend_reg && (wr_addr_reg == cfoa_pkg::OFS_FLAGS);
    assign wr_ctrl  = wr_pend_reg && (wr_addr_reg == cfoa_pkg::OFS_CTRL) && hwdata[0];

    cfoa_flag_calc u_calc (
        .flags_in  (flags_reg),
        .result    (alu_result),
        .wide      (alu_wide),
        .carry     (alu_carry),
        .overflow  (alu_overflow),
        .half      (alu_half),
        .upd       (alu_upd),
        .flags_out (alu_flags)
    );

    // Flag register update; hardware sets come last so they beat clears
    always_comb begin
        flags_next = flags_reg;
        if (alu_valid) begin
            flags_next = alu_flags;
        end
        if (ret_valid) begin
            flags_next = ret_flags;
            flags_next[cfoa_pkg::F_PRIO] = ret_flags[cfoa_pkg::F_PRIO]
                                           & flags_reg[cfoa_pkg::F_PRIO];
        end
        if (wr_flags) begin
            flags_next = hwdata[7:0];
            flags_next[cfoa_pkg::F_PRIO] = hwdata[cfoa_pkg::F_PRIO]
                                           & flags_reg[cfoa_pkg::F_PRIO];
        end
        if (imask_set) begin
            flags_next[cfoa_pkg::F_GMASK] = 1'b1;
        end
        if (nmi_ack) begin
            flags_next[cfoa_pkg::F_PRIO]  = 1'b1;
            flags_next[cfoa_pkg::F_GMASK] = 1'b1;
        end
    end

    // Opcode classification by column
    always_comb begin
        case (mem_rdata[7:4])
            4'h2: opc_mode = cfoa_pkg::M_REL;
            4'h8, 4'hC: opc_mode = cfoa_pkg::M_IMM;
            4'h9, 4'hD: opc_mode = cfoa_pkg::M_DIR;
            4'hA, 4'hE: opc_mode = cfoa_pkg::M_IDX;
            4'hB, 4'hF: opc_mode = cfoa_pkg::M_EXT;
            default: opc_mode = cfoa_pkg::M_INH;
        endcase
        // Stop sits in an immediate column but carries no operand
        if (page_reg == 2'd0 && mem_rdata == cfoa_pkg::OPC_STOP) begin
            opc_mode = cfoa_pkg::M_INH;
        end
        case (opc_mode)
            cfoa_pkg::M_INH: opc_len = 2'd0;
            cfoa_pkg::M_EXT: opc_len = 2'd2;
            cfoa_pkg::M_IMM: opc_len = (mem_rdata[3:0] == 4'h3 || mem_rdata[3:0] == 4'hC
                                        || mem_rdata[3:0] == 4'hE) ? 2'd2 : 2'd1;
            default: opc_len = 2'd1;
        endcase
    end

    // Branch condition from the flags
    always_comb begin
        case (opc_reg[3:0])
            4'h0: cond = 1'b1;
            4'h1: cond = 1'b0;
            4'h2: cond = ~(flags_reg[cfoa_pkg::F_BORROW] | flags_reg[cfoa_pkg::F_NULL]);
            4'h3: cond = flags_reg[cfoa_pkg::F_BORROW] | flags_reg[cfoa_pkg::F_NULL];
            4'h4: cond = ~flags_reg[cfoa_pkg::F_BORROW];
            4'h5: cond = flags_reg[cfoa_pkg::F_BORROW];
            4'h6: cond = ~flags_reg[cfoa_pkg::F_NULL];
            4'h7: cond = flags_reg[cfoa_pkg::F_NULL];
            4'h8: cond = ~flags_reg[cfoa_pkg::F_RANGE];
            4'h9: cond = flags_reg[cfoa_pkg::F_RANGE];
            4'hA: cond = ~flags_reg[cfoa_pkg::F_MSB];
            4'hB: cond = flags_reg[cfoa_pkg::F_MSB];
            4'hC: cond = ~(flags_reg[cfoa_pkg::F_MSB] ^ flags_reg[cfoa_pkg::F_RANGE]);
            4'hD: cond = flags_reg[cfoa_pkg::F_MSB] ^ flags_reg[cfoa_pkg::F_RANGE];
            4'hE: cond = ~(flags_reg[cfoa_pkg::F_NULL]
                           | (flags_reg[cfoa_pkg::F_MSB] ^ flags_reg[cfoa_pkg::F_RANGE]));
            default: cond = flags_reg[cfoa_pkg::F_NULL]
                            | (flags_reg[cfoa_pkg::F_MSB] ^ flags_reg[cfoa_pkg::F_RANGE]);
        endcase
    end

    assign is_pfx   = !pfx_reg && (mem_rdata == cfoa_pkg::PFX_PAGE2
                      || mem_rdata == cfoa_pkg::PFX_PAGE3 || mem_rdata == cfoa_pkg::PFX_PAGE4);
    assign fin      = (state_reg == cfoa_pkg::ST_OPND) && mem_ack && (cnt_reg == 2'd1);
    assign rel_tgt  = pc_reg + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
    // Pages 2 and 4 index through the second pointer
    assign base_ptr = page_reg[0] ? ptr2_reg : ptr1_reg;

    // Fetch and address sequencer
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        pc_next = pc_reg;
        ea_next = ea_reg;
        opnd_next = opnd_reg;
        opc_next = opc_reg;
        page_next = page_reg;
        cnt_next = cnt_reg;
        pfx_next = pfx_reg;
        taken_next = taken_reg;
        stopign_next = stopign_reg;
        stop_next = 1'b0;
        mem_req = 1'b0;
        if (wr_pend_reg && wr_addr_reg == cfoa_pkg::OFS_PC && state_reg == cfoa_pkg::ST_IDLE) begin
            pc_next = hwdata[15:0];
        end
        case (state_reg)
            cfoa_pkg::ST_IDLE: begin
                if (wr_ctrl) begin
                    state_next = cfoa_pkg::ST_OPC;
                    page_next = 2'd0;
                    pfx_next = 1'b0;
                    taken_next = 1'b0;
                    stopign_next = 1'b0;
                end
            end
            cfoa_pkg::ST_OPC: begin
                mem_req = 1'b1;
                if (mem_ack) begin
                    pc_next = pc_reg + 16'h0001;
                    if (is_pfx) begin
                        pfx_next = 1'b1;
                        page_next = (mem_rdata == cfoa_pkg::PFX_PAGE2) ? 2'd1 :
                                    (mem_rdata == cfoa_pkg::PFX_PAGE3) ? 2'd2 : 2'd3;
                    end else begin
                        opc_next = mem_rdata;
                        mode_next = opc_mode;
                        cnt_next = opc_len;
                        opnd_next = 16'h0000;
                        if (opc_mode == cfoa_pkg::M_INH) begin
                            state_next = cfoa_pkg::ST_DONE;
                            if (page_reg == 2'd0 && mem_rdata == cfoa_pkg::OPC_STOP) begin
                                stop_next = ~flags_reg[cfoa_pkg::F_HALT];
                                stopign_next = flags_reg[cfoa_pkg::F_HALT];
                            end
                        end else begin
                            state_next = cfoa_pkg::ST_OPND;
                        end
                    end
                end
            end
            cfoa_pkg::ST_OPND: begin
                mem_req = 1'b1;
                if (mem_ack) begin
                    pc_next = pc_reg + 16'h0001;
                    opnd_next = {opnd_reg[7:0], mem_rdata};
                    cnt_next = cnt_reg - 2'd1;
                end
                if (fin) begin
                    state_next = cfoa_pkg::ST_DONE;
                    case (mode_reg)
                        cfoa_pkg::M_DIR: begin
                            ea_next = {8'h00, mem_rdata};
                            state_next = cfoa_pkg::ST_DATA;
                        end
                        cfoa_pkg::M_EXT: begin
                            ea_next = {opnd_reg[7:0], mem_rdata};
                            state_next = cfoa_pkg::ST_DATA;
                        end
                        cfoa_pkg::M_IDX: begin
                            ea_next = base_ptr + {8'h00, mem_rdata};
                            state_next = cfoa_pkg::ST_DATA;
                        end
                        cfoa_pkg::M_REL: begin
                            ea_next = rel_tgt;
                            if (cond) begin
                                pc_next = rel_tgt;
                                taken_next = 1'b1;
                            end
                        end
                        default: begin
                            ea_next = pc_reg - {14'h0000, opc_len_unused(cnt_reg)};
                        end
                    endcase
                end
            end
            cfoa_pkg::ST_DATA: begin
                mem_req = 1'b1;
                if (mem_ack) begin
                    opnd_next = {8'h00, mem_rdata};
                    state_next = cfoa_pkg::ST_DONE;
                end
            end
            cfoa_pkg::ST_DONE: begin
                state_next = cfoa_pkg::ST_IDLE;
            end
            default: begin
                state_next = cfoa_pkg::ST_IDLE;
            end
        endcase
    end

    // Immediate operand address: first operand byte position
    function automatic logic [1:0] opc_len_unused(input logic [1:0] c);
        opc_len_unused = (mode_reg == cfoa_pkg::M_IMM && opc_reg[3:0] != 4'h3
                          && opc_reg[3:0] != 4'hC && opc_reg[3:0] != 4'hE) ? 2'd0 : c;
    endfunction

    // Register file, bus side
    always_comb begin
        ptr1_next = ptr1_reg;
        ptr2_next = ptr2_reg;
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
        hrdata_next = hrdata_reg;
        if (wr_pend_reg && wr_addr_reg == cfoa_pkg::OFS_PTR1) begin
            ptr1_next = hwdata[15:0];
        end
        if (wr_pend_reg && wr_addr_reg == cfoa_pkg::OFS_PTR2) begin
            ptr2_next = hwdata[15:0];
        end
        if (addr_ok && !hwrite) begin
            // Read mux takes next values so a write just before is seen
            case (haddr[7:0])
                cfoa_pkg::OFS_FLAGS:   hrdata_next = {24'h000000, flags_next};
                cfoa_pkg::OFS_PTR1:    hrdata_next = {16'h0000, ptr1_next};
                cfoa_pkg::OFS_PTR2:    hrdata_next = {16'h0000, ptr2_next};
                cfoa_pkg::OFS_PC:      hrdata_next = {16'h0000, pc_next};
                cfoa_pkg::OFS_STATUS:  hrdata_next = {16'h0000, opc_reg, stopign_reg,
                                                      taken_reg, page_reg, mode_reg,
                                                      state_reg != cfoa_pkg::ST_IDLE};
                cfoa_pkg::OFS_EA:      hrdata_next = {16'h0000, ea_reg};
                cfoa_pkg::OFS_OPERAND: hrdata_next = {16'h0000, opnd_reg};
                default:               hrdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= cfoa_pkg::ST_IDLE;
            mode_reg <= cfoa_pkg::M_INH;
            flags_reg <= cfoa_pkg::FLAGS_RST;
            ptr1_reg <= cfoa_pkg::WORD_RST;
            ptr2_reg <= cfoa_pkg::WORD_RST;
            pc_reg <= cfoa_pkg::WORD_RST;
            ea_reg <= cfoa_pkg::WORD_RST;
            opnd_reg <= cfoa_pkg::WORD_RST;
            opc_reg <= 8'h00;
            page_reg <= 2'd0;
            cnt_reg <= 2'd0;
            pfx_reg <= 1'b0;
            taken_reg <= 1'b0;
            stopign_reg <= 1'b0;
            stop_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            flags_reg <= flags_next;
            ptr1_reg <= ptr1_next;
            ptr2_reg <= ptr2_next;
            pc_reg <= pc_next;
            ea_reg <= ea_next;
            opnd_reg <= opnd_next;
            opc_reg <= opc_next;
            page_reg <= page_next;
            cnt_reg <= cnt_next;
            pfx_reg <= pfx_next;
            taken_reg <= taken_next;
            stopign_reg <= stopign_next;
            stop_reg <= stop_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            irq_meta_reg <= irq_pin;
            irq_sync_reg <= irq_meta_reg;
            irq_pend_reg <= irq_sync_reg & ~flags_next[cfoa_pkg::F_GMASK];
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic alu_only;
    assign alu_only = alu_valid && !ret_valid && !wr_flags && !imask_set && !nmi_ack;

    sequence s_pfx2;
        state_reg == cfoa_pkg::ST_OPC && mem_ack && !pfx_reg && mem_rdata == cfoa_pkg::PFX_PAGE2;
    endsequence
    sequence s_inh_fetch;
        state_reg == cfoa_pkg::ST_OPC && mem_ack && !is_pfx && opc_mode == cfoa_pkg::M_INH;
    endsequence
    sequence s_taken;
        fin && mode_reg == cfoa_pkg::M_REL && cond;
    endsequence

    prio_set_hw_a: assert property ($rose(flags_reg[cfoa_pkg::F_PRIO]) |-> $past(nmi_ack))
        else $error("priority mask rose without acknowledge");
    mask_blocks_a: assert property (flags_reg[cfoa_pkg::F_GMASK] && !$past(irq_pend_reg)
                                    |-> !irq_pending)
        else $error("maskable request passed while masked");
    null_flag_a: assert property (alu_only && alu_upd[cfoa_pkg::U_NZ] && !alu_wide
        |=> flags_reg[cfoa_pkg::F_NULL] == ($past(alu_result[7:0]) == 8'h00))
        else $error("null flag wrong");
    msb_flag_a: assert property (alu_only && alu_upd[cfoa_pkg::U_NZ] && alu_wide
        |=> flags_reg[cfoa_pkg::F_MSB] == $past(alu_result[15]))
        else $error("msb flag wrong");
    borrow_flag_a: assert property (alu_only && alu_upd[cfoa_pkg::U_BORROW]
        |=> flags_reg[cfoa_pkg::F_BORROW] == $past(alu_carry))
        else $error("borrow flag wrong");
    range_flag_a: assert property (alu_only && alu_upd[cfoa_pkg::U_RANGE]
        |=> flags_reg[cfoa_pkg::F_RANGE] == $past(alu_overflow))
        else $error("range flag wrong");
    half_flag_a: assert property (alu_only && alu_upd[cfoa_pkg::U_HALF]
        |=> flags_reg[cfoa_pkg::F_HALF] == $past(alu_half))
        else $error("nibble carry flag wrong");
    stop_gate_a: assert property (stop_enter |-> !$past(flags_reg[cfoa_pkg::F_HALT]))
        else $error("stop taken while blocked");
    direct_ea_a: assert property (state_reg == cfoa_pkg::ST_DATA && mode_reg == cfoa_pkg::M_DIR
        |-> ea_reg[15:8] == 8'h00 && mem_addr == ea_reg)
        else $error("direct address high byte not zero");
    page_two_a: assert property (s_pfx2 |=> page_reg == 2'd1 && state_reg == cfoa_pkg::ST_OPC)
        else $error("prefix did not select page 2");
    inh_nomem_a: assert property (s_inh_fetch |=> state_reg == cfoa_pkg::ST_DONE ##1
        state_reg == cfoa_pkg::ST_IDLE)
        else $error("inherent opcode touched memory");
    branch_pc_a: assert property (s_taken |=> pc_reg == $past(rel_tgt) && taken_reg)
        else $error("taken branch target wrong");
endmodule

// *** dv/cfoa_mem.sv ***
// Byte memory model feeding opcode and operand fetches
module cfoa_mem (
    // Fetch port
    input  wire logic        hclk,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic       slow = 1'b0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 8'hA5;
    // First answer prompt, every later answer after one wait; junk data when not answering
    always @(posedge hclk) begin
        slow <= slow ^ (mem_req & ~mem_ack);
        mem_ack <= mem_req & ~mem_ack & ~slow;
        mem_rdata <= (mem_req & ~mem_ack & ~slow) ? mem[mem_addr] : ~mem_rdata;
    end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the flag register and operand addressing
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req, mem_ack, alu_valid;
    logic        alu_wide, alu_carry, alu_overflow, alu_half, nmi_ack, imask_set, ret_valid;
    logic        irq_pin, irq_pending, dec_done, stop_enter;
    logic [1:0]  htrans;
    logic [3:0]  alu_upd;
    logic [7:0]  mem_rdata, ret_flags, f, p;
    logic [15:0] alu_result, mem_addr, r;
    logic [31:0] haddr, hwdata, hrdata, q, rnd;
    int          num_errors, n_compared, n_acks, n_stop, a0, n1;
    cfoa_core u_dut (.hready(hreadyout), .hsize(3'h2), .*);
    cfoa_mem u_mem (.*);
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        n_acks <= n_acks + int'(mem_req & mem_ack);
        n_stop <= n_stop + int'(stop_enter);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Flags after one outcome, o = {wide, carry, overflow, half}
    function automatic logic [7:0] efl(input logic [7:0] g, logic [15:0] v, logic [3:0] o);
        return {g[7:6], o[0], g[4], v[o[3] ? 15 : 7], (o[3] ? v : v[7:0]) == 0, o[1], o[2]};
    endfunction
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(a, 0, 0);
        chk(n, e, q);
    endtask
    task automatic dec(input logic [31:0] c);
        for (int i = 0; i < 4; i++) u_mem.mem[16'h0200 + i] = c[31 - 8 * i -: 8];
        bus(cfoa_pkg::OFS_PC, 32'h200, 1);
        bus(cfoa_pkg::OFS_CTRL, 32'h1, 1);
        a0 = n_acks;
        for (int k = 0; k < 40 && dec_done !== 1'b1; k++) @(posedge hclk);
        chk("done", 1, dec_done);
        @(posedge hclk);
        a0 = n_acks - a0;
    endtask
    task automatic end_sim;
        $display("Errors %0d of %0d compared", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        num_errors++;
        end_sim;
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, alu_valid, nmi_ack, imask_set, ret_valid, irq_pin} = '0;
        {htrans, alu_upd, alu_result, alu_wide, alu_carry, alu_overflow, alu_half} = '0;
        {haddr, hwdata, ret_flags, num_errors, n_compared, n_acks, n_stop} = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        {rnd, f} = {32'hBD55, 8'hD0};
        rd(cfoa_pkg::OFS_FLAGS, 32'hD0, "flags rst");
        irq_pin <= 1'b1;
        repeat (5) @(posedge hclk);
        chk("irq masked", 0, irq_pending);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            r = (i % 3 == 0) ? 16'h0 : rnd[15:0];
            f = efl(f, r, rnd[20:17]);
            {alu_valid, alu_upd, alu_wide, alu_carry, alu_overflow, alu_half} <= {5'h1F, rnd[20:17]};
            alu_result <= r;
            @(posedge hclk);
            alu_valid <= 1'b0;
            rd(cfoa_pkg::OFS_FLAGS, f, "alu flags");
            chk("alu nz", f[5:2], q[5:2]);
        end
        bus(cfoa_pkg::OFS_FLAGS, 0, 1);
        rd(cfoa_pkg::OFS_FLAGS, 0, "flags clr");
        repeat (4) @(posedge hclk);
        chk("irq open", 1, irq_pending);
        imask_set <= 1'b1;
        @(posedge hclk);
        imask_set <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("irq hw mask", 0, irq_pending);
        bus(cfoa_pkg::OFS_FLAGS, 32'hFF, 1);
        rd(cfoa_pkg::OFS_FLAGS, 32'hBF, "flags set");
        nmi_ack <= 1'b1;
        @(posedge hclk);
        {nmi_ack, ret_valid, ret_flags} <= {2'b01, 8'h80};
        @(posedge hclk);
        ret_valid <= 1'b0;
        rd(cfoa_pkg::OFS_FLAGS, 32'h80, "ret flags");
        // Stop with halt block set, then clear
        n1 = n_stop;
        dec(32'hCF000000);
        rd(cfoa_pkg::OFS_STATUS, 32'hCF80, "stop nop");
        chk("stop cnt", n1, n_stop);
        bus(cfoa_pkg::OFS_FLAGS, 0, 1);
        dec(32'hCF000000);
        chk("stop cnt", n1 + 1, n_stop);
        bus(8'h40, 32'hFFFF, 1);
        rd(8'h40, 0, "unmapped");
        chk("hresp", 0, hresp);
        bus(cfoa_pkg::OFS_PTR1, 32'hABCDFF80, 1);
        rd(cfoa_pkg::OFS_PTR1, 32'hFF80, "ptr1");
        rnd = lfsr(rnd);
        bus(cfoa_pkg::OFS_PTR2, {16'h0, rnd[15:0]}, 1);
        dec(32'hB6123400);
        rd(cfoa_pkg::OFS_EA, 32'h1234, "ext ea");
        n1 = a0;
        dec(32'h965A0000);
        rd(cfoa_pkg::OFS_EA, 32'h005A, "dir ea");
        chk("dir acks", n1 - 1, a0);
        dec(32'hA6F00000);
        rd(cfoa_pkg::OFS_EA, 32'h0070, "idx ea");
        for (int i = 1; i < 4; i++) begin
            p = (i == 1) ? 8'h18 : (i == 2) ? 8'h1A : 8'hCD;
            dec({p, 24'hA6F000});
            r = ((i == 2) ? 16'hFF80 : rnd[15:0]) + 16'hF0;
            rd(cfoa_pkg::OFS_EA, {16'h0, r}, "page ea");
            bus(cfoa_pkg::OFS_STATUS, 0, 0);
            chk("page", i, q[5:4]);
        end
        dec(32'h20800000);
        rd(cfoa_pkg::OFS_PC, 32'h0182, "br taken");
        dec(32'h21800000);
        rd(cfoa_pkg::OFS_PC, 32'h0202, "br not");
        dec(32'h01000000);
        chk("inh acks", 1, a0);
        dec(32'h86AB0000);
        rd(cfoa_pkg::OFS_OPERAND, 32'hAB, "imm8");
        dec(32'h8C123400);
        rd(cfoa_pkg::OFS_OPERAND, 32'h1234, "imm16");
        end_sim;
    end
endmodule
